/* include/ddrbs_pkg.sv */
// ddrbs_pkg: shared types and constants for the bank state tracker
// assumes: 250 MHz clock, four banks, commands sampled every rising edge
package ddrbs_pkg;

  localparam int NUM_BANKS = 4;

  // recovery times in clock cycles; plain defaults, no part figures
  localparam logic [7:0] PRECHARGE_RECOVERY_CYC = 8'h03;
  localparam logic [7:0] ACTIVATE_TO_ACCESS_CYC = 8'h03;
  localparam logic [7:0] REFRESH_RECOVERY_CYC   = 8'h12;
  localparam logic [7:0] MODE_REG_RECOVERY_CYC  = 8'h02;
  localparam logic [7:0] SELF_REFRESH_EXIT_CYC  = 8'h14;
  localparam logic [7:0] BURST_CYC              = 8'h04;

  // field position and address width
  localparam int ALL_BANK_BIT = 10;
  localparam int ADDR_W       = 13;

  typedef enum logic [3:0] {
    CMD_DESELECT  = 4'h0,
    CMD_NOP       = 4'h1,
    CMD_ACTIVATE  = 4'h2,
    CMD_REFRESH   = 4'h3,
    CMD_MODE_SET  = 4'h4,
    CMD_READ      = 4'h5,
    CMD_WRITE     = 4'h6,
    CMD_PRECHARGE = 4'h7,
    CMD_BURST_END = 4'h8
  } ddrbs_cmd_t;

  typedef enum logic [2:0] {
    BK_IDLE       = 3'b000,
    BK_ACTIVATING = 3'b001,
    BK_ROW_ACTIVE = 3'b010,
    BK_READING    = 3'b011,
    BK_WRITING    = 3'b100,
    BK_PRECHARGING= 3'b101
  } ddrbs_bank_t;

  typedef enum logic [2:0] {
    DV_NORMAL     = 3'b000,
    DV_PRE_PDOWN  = 3'b001,
    DV_ACT_PDOWN  = 3'b010,
    DV_SELF_REF   = 3'b011,
    DV_SREF_EXIT  = 3'b100,
    DV_GLOBAL_REC = 3'b101
  } ddrbs_mode_t;

  typedef struct packed {
    logic              chip_sel_n;
    logic              row_strobe_n;
    logic              col_strobe_n;
    logic              write_strobe_n;
    logic [1:0]        bank_sel;
    logic [ADDR_W-1:0] addr;
  } ddrbs_cmd_bus_t;

endpackage

/* design/ddrbs_core.sv */
// ddrbs_core: per-bank state, power-down and self refresh tracking
// assumes: controller pins already synchronous to mclk_i
`timescale 1ns/1ps
module ddrbs_core
  import ddrbs_pkg::*;
(
  // clock and reset
  input  wire logic           mclk_i,
  input  wire logic           reset_n_i,
  // controller pins
  input  wire ddrbs_cmd_bus_t cmd_i,
  input  wire logic           clk_en_i,
  // status
  output logic [11:0]         bank_state_o,
  output logic [2:0]          dev_mode_o,
  output logic                in_buf_en_o,
  output logic                read_active_o,
  output logic [1:0]          read_bank_o,
  output logic                all_idle_o
);

  // ==========================================================
  // input synchronisers
  ddrbs_cmd_bus_t cmd_s1_q, cmd_s2_q;
  logic           cke_s1_q, cke_s2_q, cke_prev_q;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_s1_q   <= '{chip_sel_n: 1'b1, row_strobe_n: 1'b1, col_strobe_n: 1'b1,
                      write_strobe_n: 1'b1, default: '0};
      cmd_s2_q   <= '{chip_sel_n: 1'b1, row_strobe_n: 1'b1, col_strobe_n: 1'b1,
                      write_strobe_n: 1'b1, default: '0};
      cke_s1_q   <= 1'b0;
      cke_s2_q   <= 1'b0;
      cke_prev_q <= 1'b0;
    end else begin
      cmd_s1_q   <= cmd_i;
      cmd_s2_q   <= cmd_s1_q;
      cke_s1_q   <= clk_en_i;
      cke_s2_q   <= cke_s1_q;
      cke_prev_q <= cke_s2_q;
    end
  end

  // ==========================================================
  // command decode
  ddrbs_cmd_t cmd;
  always_comb begin
    if (cmd_s2_q.chip_sel_n) begin
      cmd = CMD_DESELECT;
    end else begin
      case ({cmd_s2_q.row_strobe_n, cmd_s2_q.col_strobe_n, cmd_s2_q.write_strobe_n})
        3'b111:  cmd = CMD_NOP;
        3'b011:  cmd = CMD_ACTIVATE;
        3'b001:  cmd = CMD_REFRESH;
        3'b000:  cmd = CMD_MODE_SET;
        3'b101:  cmd = CMD_READ;
        3'b100:  cmd = CMD_WRITE;
        3'b010:  cmd = CMD_PRECHARGE;
        default: cmd = CMD_BURST_END;
      endcase
    end
  end

  logic all_bank, run, any_open, idle_all;
  ddrbs_mode_t mode_q;
  logic [7:0]  gcnt_q;
  assign all_bank = cmd_s2_q.addr[ALL_BANK_BIT];
  // banks step only while clock enable high now and before
  assign run      = cke_prev_q && cke_s2_q && (mode_q == DV_NORMAL);

  // ==========================================================
  // per-bank state
  ddrbs_bank_t bank_q [NUM_BANKS];
  logic [7:0]  cnt_q  [NUM_BANKS];
  logic [NUM_BANKS-1:0] open_v, idle_v;
  logic [1:0]  rd_bank_q;
  logic        rd_act_q;

  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    logic hit, pre_hit;
    assign hit     = (cmd_s2_q.bank_sel == 2'(b));
    assign pre_hit = (cmd == CMD_PRECHARGE) && (all_bank || hit);
    assign open_v[b] = (bank_q[b] != BK_IDLE) && (bank_q[b] != BK_PRECHARGING);
    assign idle_v[b] = (bank_q[b] == BK_IDLE);

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        bank_q[b] <= BK_IDLE;
        cnt_q[b]  <= 8'h00;
      end else if (run) begin
        if (pre_hit) begin
          bank_q[b] <= BK_PRECHARGING;
          cnt_q[b]  <= PRECHARGE_RECOVERY_CYC;
        end else if (hit && cmd == CMD_ACTIVATE) begin
          bank_q[b] <= BK_ACTIVATING;
          cnt_q[b]  <= ACTIVATE_TO_ACCESS_CYC;
        end else if (hit && cmd == CMD_READ) begin
          bank_q[b] <= BK_READING;
          cnt_q[b]  <= BURST_CYC;
        end else if (hit && cmd == CMD_WRITE) begin
          bank_q[b] <= BK_WRITING;
          cnt_q[b]  <= BURST_CYC;
        end else if (cmd == CMD_BURST_END && rd_act_q && rd_bank_q == 2'(b)
                     && bank_q[b] == BK_READING) begin
          bank_q[b] <= BK_ROW_ACTIVE;
          cnt_q[b]  <= 8'h00;
        end else if (cnt_q[b] > 8'h01) begin
          cnt_q[b]  <= cnt_q[b] - 8'h01;
        end else begin
          cnt_q[b]  <= 8'h00;
          case (bank_q[b])
            BK_PRECHARGING: bank_q[b] <= BK_IDLE;
            BK_ACTIVATING,
            BK_READING,
            BK_WRITING:     bank_q[b] <= BK_ROW_ACTIVE;
            default:        bank_q[b] <= bank_q[b];
          endcase
        end
      end
    end
    assign bank_state_o[3*b +: 3] = bank_q[b];
  end

  assign any_open = |open_v;
  assign idle_all = &idle_v;

  // ==========================================================
  // most recent read burst
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_act_q  <= 1'b0;
      rd_bank_q <= 2'h0;
    end else if (run) begin
      if (cmd == CMD_READ) begin
        rd_act_q  <= 1'b1;
        rd_bank_q <= cmd_s2_q.bank_sel;
      end else if (cmd == CMD_BURST_END || cmd == CMD_WRITE ||
                   (cmd == CMD_PRECHARGE && (all_bank || cmd_s2_q.bank_sel == rd_bank_q))
                   || bank_q[rd_bank_q] != BK_READING) begin
        rd_act_q  <= 1'b0;
      end
    end
  end

  // ==========================================================
  // device mode: power-down, self refresh, global recovery
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_q <= DV_NORMAL;
      gcnt_q <= 8'h00;
    end else begin
      case (mode_q)
        DV_NORMAL: begin
          if (cke_prev_q && !cke_s2_q) begin
            if (cmd == CMD_REFRESH && idle_all)
              mode_q <= DV_SELF_REF;
            else if (idle_all)
              mode_q <= DV_PRE_PDOWN;
            else
              mode_q <= DV_ACT_PDOWN;
          end else if (cke_s2_q && (cmd == CMD_REFRESH || cmd == CMD_MODE_SET)) begin
            mode_q <= DV_GLOBAL_REC;
            gcnt_q <= (cmd == CMD_REFRESH) ? REFRESH_RECOVERY_CYC : MODE_REG_RECOVERY_CYC;
          end
        end
        DV_PRE_PDOWN,
        DV_ACT_PDOWN: begin
          if (cke_s2_q) mode_q <= DV_NORMAL;
        end
        DV_SELF_REF: begin
          if (cke_s2_q) begin
            mode_q <= DV_SREF_EXIT;
            gcnt_q <= SELF_REFRESH_EXIT_CYC;
          end
        end
        DV_SREF_EXIT,
        DV_GLOBAL_REC: begin
          if (gcnt_q > 8'h01) gcnt_q <= gcnt_q - 8'h01;
          else begin
            gcnt_q <= 8'h00;
            mode_q <= DV_NORMAL;
          end
        end
        default: mode_q <= DV_NORMAL;
      endcase
    end
  end

  // ==========================================================
  // registered status outputs
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dev_mode_o    <= DV_NORMAL;
      in_buf_en_o   <= 1'b1;
      read_active_o <= 1'b0;
      read_bank_o   <= 2'h0;
      all_idle_o    <= 1'b1;
    end else begin
      dev_mode_o    <= mode_q;
      in_buf_en_o   <= !(mode_q == DV_PRE_PDOWN || mode_q == DV_ACT_PDOWN ||
                         mode_q == DV_SELF_REF);
      read_active_o <= rd_act_q;
      read_bank_o   <= rd_bank_q;
      all_idle_o    <= idle_all && !any_open;
    end
  end

endmodule // ddrbs_core

/* tb/ddrbs_core_monitor.sv */
// ddrbs_core_monitor: assertions on bank state and power-down ports
// assumes: bound into ddrbs_core, single clock domain
`timescale 1ns/1ps
module ddrbs_core_monitor
  import ddrbs_pkg::*;
(
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        reset_n_i,
  // watched ports
  input wire logic        clk_en_i,
  input wire logic [11:0] bank_state_o,
  input wire logic [2:0]  dev_mode_o,
  input wire logic        in_buf_en_o,
  input wire logic        read_active_o,
  input wire logic [1:0]  read_bank_o,
  input wire logic        all_idle_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  chk_idle_flag: assert property (
    1 |=> all_idle_o == ($past(bank_state_o) == 12'h000)) else $error("idle flag wrong");
  chk_pre_pdown: assert property (
    dev_mode_o == DV_PRE_PDOWN |-> bank_state_o == 12'h000) else $error("banks busy");
  chk_act_pdown: assert property (
    dev_mode_o == DV_ACT_PDOWN |-> bank_state_o != 12'h000) else $error("banks idle");
  chk_cke_low_off: assert property (
    !clk_en_i [*6] |-> !in_buf_en_o) else $error("buffers on");
  chk_cke_high_on: assert property (
    clk_en_i [*6] |-> in_buf_en_o) else $error("buffers off");
  chk_read_bank: assert property (
    $rose(read_active_o) |-> 3'($past(bank_state_o) >> (read_bank_o * 3)) == BK_READING)
    else $error("read bank wrong");
  chk_act_delay: assert property (
    bank_state_o[5:3] == BK_ACTIVATING && $past(bank_state_o[5:3]) != BK_ACTIVATING
    |-> (bank_state_o[5:3] == BK_ACTIVATING) [*3] ##1 bank_state_o[5:3] == BK_ROW_ACTIVE)
    else $error("activate delay wrong");
  chk_pre_delay: assert property (
    bank_state_o[5:3] == BK_PRECHARGING && $past(bank_state_o[5:3]) != BK_PRECHARGING
    |-> (bank_state_o[5:3] == BK_PRECHARGING) [*3] ##1 bank_state_o[5:3] == BK_IDLE)
    else $error("precharge delay wrong");
endmodule // ddrbs_core_monitor

bind ddrbs_core ddrbs_core_monitor i_ddrbs_core_monitor (.mclk_i(mclk_i),
  .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .bank_state_o(bank_state_o),
  .dev_mode_o(dev_mode_o), .in_buf_en_o(in_buf_en_o), .read_active_o(read_active_o),
  .read_bank_o(read_bank_o), .all_idle_o(all_idle_o));

/* tb/ddrbs_ctrl_model.sv */
// ddrbs_ctrl_model: memory controller issuing commands and clock enable
// assumes: caller keeps recovery spacing through the gap argument
`timescale 1ns/1ps
module ddrbs_ctrl_model
  import ddrbs_pkg::*;
(
  // clock
  input  wire logic      mclk_i,
  // controller pins
  output ddrbs_cmd_bus_t cmd_o,
  output logic           clk_en_o
);
  localparam logic [3:0] ENC [9] = '{4'h8, 4'h7, 4'h3, 4'h1, 4'h0, 4'h5, 4'h4, 4'h2, 4'h6};
  initial begin
    cmd_o = '1;
    clk_en_o = 1'h1;
  end
  task automatic send(input ddrbs_cmd_t c, input logic [1:0] b, input logic a10,
                      input logic ke, input int gap);
    @(posedge mclk_i);
    cmd_o <= {ENC[c], b, 2'($urandom), a10, 10'($urandom)};
    clk_en_o <= ke;
    repeat (gap) begin
      @(posedge mclk_i);
      cmd_o <= {4'h8 | 4'($urandom & 7), 2'($urandom), 13'($urandom)};
    end
  endtask
endmodule // ddrbs_ctrl_model

/* tb/test_ddrbs_core.sv */
// test_ddrbs_core: drives commands, checks bank state and device modes
// assumes: ddrbs_pkg, core, model and monitor compiled first
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module test_ddrbs_core import ddrbs_pkg::*; ;
  ddrbs_cmd_bus_t cmd;
  logic           mclk_i = 1'h0;
  logic           reset_n_i = 1'h0;
  logic           ke, buf_on, rd_act, idle;
  logic [1:0]     rd_bank;
  logic [2:0]     mode;
  logic [11:0]    banks, exp_v, prev_q = 12'h000;
  logic [11:0]    exp_q[$];
  int             fails = 0;
  int             samples_checked = 0;
  always #2 mclk_i = ~mclk_i;
  ddrbs_core i_ddrbs_core (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cmd_i(cmd),
    .clk_en_i(ke), .bank_state_o(banks), .dev_mode_o(mode), .in_buf_en_o(buf_on),
    .read_active_o(rd_act), .read_bank_o(rd_bank), .all_idle_o(idle));
  ddrbs_ctrl_model i_ddrbs_ctrl_model (.mclk_i(mclk_i), .cmd_o(cmd), .clk_en_o(ke));
  // each bank change must match the oldest noted expectation
  always @(negedge mclk_i) begin
    if (reset_n_i && banks !== prev_q) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : prev_q;
      `CHK(banks, exp_v)
    end
    prev_q <= banks;
  end
  task automatic go(ddrbs_cmd_t c, logic [1:0] b, logic a, logic k, int g,
                    logic [11:0] e1, logic [11:0] e2);
    if (e1 != 12'hfff) exp_q.push_back(e1);
    if (e2 != 12'hfff) exp_q.push_back(e2);
    i_ddrbs_ctrl_model.send(c, b, a, k, g);
  endtask
  task automatic mode_is(logic [2:0] m, logic on);
    #1;
    `CHK(mode, m)
    `CHK(buf_on, on)
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    results();
  end
  initial begin
    void'($urandom(1));
    repeat (8) @(posedge mclk_i);
    reset_n_i <= 1'h1;
    go(CMD_ACTIVATE, 2'h1, 1'h0, 1'h1, 8, 12'h008, 12'h010);
    go(CMD_ACTIVATE, 2'h2, 1'h0, 1'h1, 8, 12'h050, 12'h090);
    go(CMD_READ, 2'h2, 1'h0, 1'h1, 1, 12'h0d0, 12'h090);
    go(CMD_BURST_END, 2'h0, 1'h0, 1'h1, 4, 12'hfff, 12'hfff);
    #1 `CHK(banks, 12'h090)
    `CHK({rd_act, rd_bank}, 3'h2)
    go(CMD_WRITE, 2'h1, 1'h0, 1'h1, 2, 12'h0a0, 12'hfff);
    go(CMD_PRECHARGE, 2'h1, 1'h0, 1'h1, 8, 12'h0a8, 12'h080);
    go(CMD_PRECHARGE, 2'($urandom), 1'h1, 1'h1, 8, 12'hb6d, 12'h000);
    $display("bank tests done");
    go(CMD_NOP, 2'h0, 1'h0, 1'h0, 10, 12'hfff, 12'hfff);
    mode_is(DV_PRE_PDOWN, 1'h0);
    go(CMD_NOP, 2'h0, 1'h0, 1'h1, 8, 12'hfff, 12'hfff);
    mode_is(DV_NORMAL, 1'h1);
    go(CMD_ACTIVATE, 2'h3, 1'h0, 1'h1, 8, 12'h200, 12'h400);
    go(CMD_NOP, 2'h0, 1'h0, 1'h0, 10, 12'hfff, 12'hfff);
    mode_is(DV_ACT_PDOWN, 1'h0);
    `CHK(idle, 1'h0)
    go(CMD_NOP, 2'h0, 1'h0, 1'h1, 8, 12'hfff, 12'hfff);
    mode_is(DV_NORMAL, 1'h1);
    go(CMD_PRECHARGE, 2'h3, 1'h0, 1'h1, 8, 12'ha00, 12'h000);
    $display("power-down tests done");
    go(CMD_REFRESH, 2'h0, 1'h0, 1'h1, 6, 12'hfff, 12'hfff);
    mode_is(DV_GLOBAL_REC, 1'h1);
    go(CMD_DESELECT, 2'h0, 1'h0, 1'h1, 20, 12'hfff, 12'hfff);
    go(CMD_MODE_SET, 2'h0, 1'h0, 1'h1, 4, 12'hfff, 12'hfff);
    mode_is(DV_GLOBAL_REC, 1'h1);
    go(CMD_DESELECT, 2'h0, 1'h0, 1'h1, 8, 12'hfff, 12'hfff);
    go(CMD_REFRESH, 2'h0, 1'h0, 1'h0, 10, 12'hfff, 12'hfff);
    mode_is(DV_SELF_REF, 1'h0);
    go(CMD_NOP, 2'h0, 1'h0, 1'h1, 4, 12'hfff, 12'hfff);
    mode_is(DV_SREF_EXIT, 1'h1);
    go(CMD_DESELECT, 2'h0, 1'h0, 1'h1, 30, 12'hfff, 12'hfff);
    mode_is(DV_NORMAL, 1'h1);
    $display("refresh tests done");
    `CHK(idle, 1'h1)
    `CHK(exp_q.size(), 0)
    results();
  end
endmodule // test_ddrbs_core
